/* File: verilog/pspc_pkg.sv */
// Package of constants and types for the pin strap and power control block
package pspc_pkg;
  localparam int CLK_HZ = 125_000_000;
  localparam int XTAL_HZ = 4_000_000;
  localparam int BAUD_FAST = 38400;
  localparam int BAUD_SLOW = 9600;
  localparam logic [15:0] BAUD_FAST_CYC = 16'(CLK_HZ / BAUD_FAST);
  localparam logic [15:0] BAUD_SLOW_CYC = 16'(CLK_HZ / BAUD_SLOW);
  localparam int SER_DATA_BITS = 8;
  localparam int SER_STOP_BITS = 1;
  // Millisecond tick drives every long timer
  localparam int TICK_MS = 1;
  localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam int DEBOUNCE_MS = 50;
  localparam int WAKE_SHORT_S = 1;
  localparam int WAKE_LONG_S = 5;
  localparam logic [12:0] DEBOUNCE_TICKS = 13'(DEBOUNCE_MS / TICK_MS);
  localparam logic [12:0] WAKE_SHORT_TICKS = 13'(WAKE_SHORT_S * 1000 / TICK_MS);
  localparam logic [12:0] WAKE_LONG_TICKS = 13'(WAKE_LONG_S * 1000 / TICK_MS);
  localparam int STRAP_SETTLE = 3;
  // Register offsets
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_POWER_OPT = 8'h04;
  localparam logic [7:0] OFS_BAUD_PARAM = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  // Command register bits (write one to act)
  localparam int CMD_MEM_ON = 0;
  localparam int CMD_MEM_OFF = 1;
  localparam int CMD_LF_ON = 2;
  localparam int CMD_LF_OFF = 3;
  localparam int CMD_SLEEP = 4;
  // Power option fields
  localparam int PO_WAKE_SEL = 1;
  localparam int PO_IGN_EN = 2;
  localparam int PO_RUN_LEVEL = 6;
  localparam int PO_PWR_CTRL = 7;
  localparam logic [7:0] POWER_OPT_RST = 8'h80;
  localparam logic [15:0] BAUD_PARAM_RST = BAUD_FAST_CYC;
  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_SLEEP = 3'b010,
    ST_WAKE = 3'b100
  } pspc_state_t;
  typedef struct packed {
    logic mem_en;
    logic lf_en;
    logic baud_fast;
  } pspc_cfg_t;
  typedef struct packed {
    logic srx;
    logic stx;
    logic vrx;
    logic vtx;
  } pspc_act_t;
endpackage

/* File: verilog/pspc_top.sv */
// Pin strap sampling, power control and pin level handling with APB access
`timescale 1ns/100ps
`default_nettype none
module pspc_top
  import pspc_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
)(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Strap pins
  input wire logic memory_strap,
  input wire logic baud_strap,
  input wire logic line_end_strap,
  // Power pins
  input wire logic ignition_monitor_input,
  output logic power_switch_output,
  output logic osc_enable,
  // Vehicle bus pins
  input wire logic variable_pulse_bus_input,
  input wire logic kline_receive_n,
  input wire logic pwm_receive_n,
  output logic negative_line_drive_output,
  // Serial pins
  output logic serial_transmit_output,
  input wire logic serial_receive_input,
  // Activity indicators
  output logic serial_rx_led_n,
  output logic serial_tx_led_n,
  output logic vehicle_rx_led_n,
  output logic vehicle_tx_led_n,
  // Engine side
  input wire logic cmd_busy,
  input wire logic serial_tx_line,
  input wire logic pwm_dominant_req,
  input wire pspc_act_t activity,
  output pspc_cfg_t cfg,
  output logic [15:0] baud_cycles,
  output logic rts_request,
  output logic warm_start,
  output logic [2:0] bus_dominant,
  output logic serial_rx_level
);

  function automatic logic [31:0] rd_word(input logic [15:0] v);
    rd_word = {16'h0000, v};
  endfunction

  // Pin synchronisers reset to idle levels so no false edge follows reset
  logic [6:0] pin_s1_r;
  logic [6:0] pin_s2_r;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      pin_s1_r <= 7'h76;
      pin_s2_r <= 7'h76;
    end
    else
    begin
      pin_s1_r <= {serial_receive_input, pwm_receive_n, kline_receive_n,
                   variable_pulse_bus_input, ignition_monitor_input,
                   baud_strap, memory_strap};
      pin_s2_r <= pin_s1_r;
    end

  logic strap_line_s1_r;
  logic strap_lf_s_r;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      strap_line_s1_r <= 1'b0;
      strap_lf_s_r <= 1'b0;
    end
    else
    begin
      strap_line_s1_r <= line_end_strap;
      strap_lf_s_r <= strap_line_s1_r;
    end

  logic dual_in_s;
  assign dual_in_s = pin_s2_r[2];

  // APB slave: no wait state; read data leaves a flop loaded in the setup phase
  logic [7:0] power_opt_r;
  logic [15:0] baud_param_r;
  logic [4:0] status_v;
  logic wr_en;
  logic [31:0] rd_nxt;
  logic err_nxt;
  pspc_state_t st_r;
  assign wr_en = psel && penable && pready && pwrite && !pslverr;

  always_comb
  begin
    rd_nxt = 32'h0000_0000;
    err_nxt = 1'b0;
    case (paddr)
      OFS_CMD: rd_nxt = 32'h0000_0000;
      OFS_POWER_OPT: rd_nxt = rd_word({8'h00, power_opt_r});
      OFS_BAUD_PARAM: rd_nxt = rd_word(baud_param_r);
      OFS_STATUS: rd_nxt = rd_word({8'h00, st_r, status_v});
      default: err_nxt = 1'b1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else if (psel && !penable)
    begin
      pready <= 1'b1;
      pslverr <= err_nxt;
      prdata <= pwrite ? 32'h0000_0000 : rd_nxt;
    end
    else
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end

  logic [4:0] cmd_v;
  assign cmd_v = (wr_en && paddr == OFS_CMD) ? pwdata[4:0] : 5'h00;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      power_opt_r <= POWER_OPT_RST;
    else if (wr_en && paddr == OFS_POWER_OPT)
      power_opt_r <= pwdata[7:0];

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      baud_param_r <= BAUD_PARAM_RST;
    else if (wr_en && paddr == OFS_BAUD_PARAM)
      baud_param_r <= pwdata[15:0];

  // Strap capture once synchronisers have settled after reset release
  logic [1:0] settle_r;
  logic strap_done_r;
  logic strap_take;
  assign strap_take = !strap_done_r && settle_r == 2'(STRAP_SETTLE - 1);
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      settle_r <= 2'h0;
      strap_done_r <= 1'b0;
    end
    else if (!strap_done_r)
    begin
      settle_r <= settle_r + 2'h1;
      strap_done_r <= strap_take;
    end

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      cfg.mem_en <= 1'b0;
    else if (cmd_v[CMD_MEM_ON])
      cfg.mem_en <= 1'b1;
    else if (cmd_v[CMD_MEM_OFF])
      cfg.mem_en <= 1'b0;
    else if (strap_take)
      cfg.mem_en <= pin_s2_r[0];

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      cfg.lf_en <= 1'b0;
    else if (cmd_v[CMD_LF_ON])
      cfg.lf_en <= 1'b1;
    else if (cmd_v[CMD_LF_OFF])
      cfg.lf_en <= 1'b0;
    else if (strap_take)
      cfg.lf_en <= strap_lf_s_r;

  // Rate follows the parameter live; the strap only picks which source
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      cfg.baud_fast <= 1'b0;
      baud_cycles <= BAUD_SLOW_CYC;
    end
    else
    begin
      if (strap_take)
        cfg.baud_fast <= pin_s2_r[1];
      baud_cycles <= cfg.baud_fast ? baud_param_r : BAUD_SLOW_CYC;
    end

  // Millisecond enable; the divider keeps running in standby since pclk
  // here is not the gated crystal clock
  logic [$clog2(TICK_CYCLES)-1:0] div_r;
  logic tick;
  assign tick = div_r == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1);
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      div_r <= '0;
    else
      div_r <= tick ? '0 : div_r + 1'b1;

  logic ign_mode;
  assign ign_mode = power_opt_r[PO_PWR_CTRL] && power_opt_r[PO_IGN_EN];

  logic dual_prev_r;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      dual_prev_r <= 1'b1;
    else
      dual_prev_r <= dual_in_s;
  logic dual_rise;
  assign dual_rise = dual_in_s && !dual_prev_r;

  // Debounce: low level must persist for the full count
  logic [12:0] deb_r;
  logic deb_hit;
  assign deb_hit = deb_r >= DEBOUNCE_TICKS;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      deb_r <= 13'h0000;
    else if (dual_in_s || !ign_mode || st_r != ST_RUN)
      deb_r <= 13'h0000;
    else if (tick && !deb_hit)
      deb_r <= deb_r + 13'h0001;

  logic [12:0] wake_r;
  logic [12:0] wake_target;
  assign wake_target = power_opt_r[PO_WAKE_SEL] ? WAKE_LONG_TICKS
                                                : WAKE_SHORT_TICKS;
  logic wake_done;
  assign wake_done = tick && wake_r >= wake_target - 13'h0001;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      wake_r <= 13'h0000;
    else if (st_r != ST_WAKE)
      wake_r <= 13'h0000;
    else if (tick)
      wake_r <= wake_r + 13'h0001;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      st_r <= ST_RUN;
    else
      case (st_r)
        ST_RUN:
          if (cmd_v[CMD_SLEEP] || deb_hit)
            st_r <= ST_SLEEP;
        ST_SLEEP:
          if (dual_rise)
            st_r <= ST_WAKE;
        ST_WAKE:
          if (!dual_in_s)
            st_r <= ST_SLEEP;
          else if (wake_done)
            st_r <= ST_RUN;
        default:
          st_r <= ST_RUN;
      endcase

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      warm_start <= 1'b0;
    else
      warm_start <= st_r == ST_WAKE && dual_in_s && wake_done;

  // Crystal stays on during the wake wait so the delay can be timed
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      osc_enable <= 1'b1;
    else
      osc_enable <= st_r != ST_SLEEP;

  // Host keeps the request low until busy falls, so a level is enough
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      rts_request <= 1'b0;
    else
      rts_request <= !ign_mode && !dual_in_s && st_r == ST_RUN;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      power_switch_output <= POWER_OPT_RST[PO_RUN_LEVEL];
    else if (power_opt_r[PO_PWR_CTRL])
      power_switch_output <= power_opt_r[PO_RUN_LEVEL] ^ (st_r == ST_SLEEP);
    else
      power_switch_output <= cmd_busy;

  // Normalised dominant flags: {pwm, kline, vpw}
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      bus_dominant <= 3'h0;
      serial_rx_level <= 1'b1;
      negative_line_drive_output <= 1'b0;
      serial_transmit_output <= 1'b1;
    end
    else
    begin
      bus_dominant[0] <= pin_s2_r[3];
      bus_dominant[1] <= !pin_s2_r[4];
      bus_dominant[2] <= !pin_s2_r[5];
      serial_rx_level <= pin_s2_r[6];
      negative_line_drive_output <= pwm_dominant_req && st_r == ST_RUN;
      // Framing (8N1) comes from the engine; idle is forced high here
      serial_transmit_output <= serial_tx_line || st_r != ST_RUN;
    end

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      serial_rx_led_n <= 1'b1;
      serial_tx_led_n <= 1'b1;
      vehicle_rx_led_n <= 1'b1;
      vehicle_tx_led_n <= 1'b1;
    end
    else
    begin
      serial_rx_led_n <= !activity.srx;
      serial_tx_led_n <= !activity.stx;
      vehicle_rx_led_n <= !activity.vrx;
      vehicle_tx_led_n <= !activity.vtx;
    end

  assign status_v = {rts_request, ign_mode, cfg.baud_fast, cfg.lf_en,
                     cfg.mem_en};

  // Assertions
  property p_mem_strap;
    @(posedge pclk) disable iff (!presetn)
    strap_take && cmd_v[1:0] == 2'h0 |=> cfg.mem_en == $past(pin_s2_r[0]);
  endproperty
  a_mem_strap: assert property (p_mem_strap)
    else $error("memory default not taken from strap");

  property p_strap_ignored;
    @(posedge pclk) disable iff (!presetn)
    strap_done_r && cmd_v == 5'h00 |=> $stable(cfg);
  endproperty
  a_strap_ignored: assert property (p_strap_ignored)
    else $error("configuration changed without a command");

  property p_lf_cmd;
    @(posedge pclk) disable iff (!presetn)
    cmd_v[CMD_LF_ON] |=> cfg.lf_en ##1 1'b1;
  endproperty
  a_lf_cmd: assert property (p_lf_cmd)
    else $error("linefeed-on command lost");

  property p_sleep_entry;
    @(posedge pclk) disable iff (!presetn)
    st_r == ST_RUN && deb_hit |=> st_r == ST_SLEEP ##1 !osc_enable;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry)
    else $error("debounced low did not enter standby");

  property p_wake_edge;
    @(posedge pclk) disable iff (!presetn)
    st_r == ST_SLEEP && dual_rise |=> st_r == ST_WAKE;
  endproperty
  a_wake_edge: assert property (p_wake_edge)
    else $error("rising edge did not leave standby");

  property p_warm;
    @(posedge pclk) disable iff (!presetn)
    st_r == ST_WAKE && dual_in_s && wake_done |=> st_r == ST_RUN && warm_start;
  endproperty
  a_warm: assert property (p_warm)
    else $error("warm start missing after wake delay");

  property p_pwr_level;
    @(posedge pclk) disable iff (!presetn)
    power_opt_r[PO_PWR_CTRL] && st_r == ST_SLEEP |=>
      power_switch_output == !$past(power_opt_r[PO_RUN_LEVEL]);
  endproperty
  a_pwr_level: assert property (p_pwr_level)
    else $error("power output not inverted in standby");

  property p_busy;
    @(posedge pclk) disable iff (!presetn)
    !power_opt_r[PO_PWR_CTRL] |=> power_switch_output == $past(cmd_busy);
  endproperty
  a_busy: assert property (p_busy)
    else $error("busy output wrong");

  property p_rts;
    @(posedge pclk) disable iff (!presetn)
    !ign_mode && !dual_in_s && st_r == ST_RUN |=> rts_request;
  endproperty
  a_rts: assert property (p_rts)
    else $error("request-to-send not flagged");

  property p_led;
    @(posedge pclk) disable iff (!presetn)
    activity.srx ##1 activity.srx |-> !serial_rx_led_n;
  endproperty
  a_led: assert property (p_led)
    else $error("serial receive indicator not low");

  c_sleep: cover property (@(posedge pclk) disable iff (!presetn)
    st_r == ST_SLEEP);
  c_warm: cover property (@(posedge pclk) disable iff (!presetn)
    warm_start);
  c_busy_mode: cover property (@(posedge pclk) disable iff (!presetn)
    !power_opt_r[PO_PWR_CTRL] && cmd_busy);

endmodule
`default_nettype wire

/* File: verif/pspc_host.sv */
// Host side model: request handshake and serial receive idle level
`timescale 1ns/100ps
`default_nettype none
module pspc_host (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bench control
  input wire logic ign_on,
  input wire logic attn,
  // Device pins
  input wire logic busy,
  output logic ign_pin,
  output logic rx_pin
);
  logic low_r;
  logic seen_r;
  // Receive line rests high between characters
  assign rx_pin = 1'b1;
  assign ign_pin = ign_on & ~low_r;
  // Release only after busy has been seen high and then low again
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      low_r <= 1'b0;
      seen_r <= 1'b0;
    end
    else if (attn)
    begin
      low_r <= 1'b1;
      seen_r <= 1'b0;
    end
    else if (low_r && busy)
      seen_r <= 1'b1;
    else if (low_r && seen_r)
      low_r <= 1'b0;
  end
endmodule
`default_nettype wire

/* File: verif/pspc_top_tb.sv */
// Self-checking bench for the strap, power and pin control block
`timescale 1ns/100ps
`default_nettype none
module pspc_top_tb
  import pspc_pkg::*;
;
  // Short tick keeps the multi-second wake waits within the run budget
  localparam int TK = 4;
  localparam int DB = int'(DEBOUNCE_TICKS);
  typedef struct packed {
    logic [4:0] cmd;
    pspc_act_t act;
    logic [2:0] pins;
    logic req;
    logic tx;
    pspc_cfg_t cfg;
    logic [2:0] dom;
  } pspc_row_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic m_s, b_s, l_s, ign_on, attn, ign, osc, pso, rxp, srl;
  logic vpw, kl_n, pw_n, negd, stx, srx_n, stx_n, vrx_n, vtx_n;
  logic busy, txl, preq, rts, warm;
  logic [15:0] baudc;
  logic [2:0] dom;
  pspc_act_t act;
  pspc_cfg_t cfg;
  pspc_row_t rows [6];
  int err_total, tests_run, cyc;

  pspc_top #(.TICK_CYCLES(TK)) i_pspc_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .memory_strap(m_s),
    .baud_strap(b_s), .line_end_strap(l_s),
    .ignition_monitor_input(ign), .power_switch_output(pso),
    .osc_enable(osc), .variable_pulse_bus_input(vpw),
    .kline_receive_n(kl_n), .pwm_receive_n(pw_n),
    .negative_line_drive_output(negd), .serial_transmit_output(stx),
    .serial_receive_input(rxp), .serial_rx_led_n(srx_n),
    .serial_tx_led_n(stx_n), .vehicle_rx_led_n(vrx_n),
    .vehicle_tx_led_n(vtx_n), .cmd_busy(busy), .serial_tx_line(txl),
    .pwm_dominant_req(preq), .activity(act), .cfg(cfg),
    .baud_cycles(baudc), .rts_request(rts), .warm_start(warm),
    .bus_dominant(dom), .serial_rx_level(srl));

  pspc_host i_pspc_host (.pclk(pclk), .presetn(presetn), .ign_on(ign_on),
    .attn(attn), .busy(pso), .ign_pin(ign), .rx_pin(rxp));

  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 80000)
    begin
      err_total = err_total + 1;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e,
                     input string m);
    tests_run++;
    if (g !== e)
    begin
      err_total++;
      $display("FAIL t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    // Take the answer at the rising edge that completes the access
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk(32'(pready === 1'b1), 32'h1, "pready");
  endtask

  task automatic do_reset(input logic [2:0] s);
    @(posedge pclk);
    {m_s, b_s, l_s} <= s;
    presetn <= 1'b0;
    repeat (2) @(negedge pclk);
    chk({srx_n, stx_n, vrx_n, vtx_n, stx, osc}, 32'h3f, "rst pins");
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
    @(negedge pclk);
    chk(cfg, {s[2], s[0], s[1]}, "strap cfg");
    chk(baudc, s[1] ? BAUD_FAST_CYC : BAUD_SLOW_CYC, "baud");
  endtask

  task automatic ign_set(input logic v);
    @(posedge pclk);
    ign_on <= v;
  endtask

  function automatic logic pick(input int s);
    return s ? warm : osc;
  endfunction

  task automatic wait_sig(input int s, input logic v, output int n);
    n = 0;
    @(negedge pclk);
    while (pick(s) !== v && n < 30000)
    begin
      @(negedge pclk);
      n++;
    end
  endtask

  task automatic sleep_wake(input logic [7:0] opt, input logic bycmd);
    int n;
    int w;
    w = TK * int'(opt[1] ? WAKE_LONG_TICKS : WAKE_SHORT_TICKS);
    apb(1'b1, OFS_POWER_OPT, {24'h0, opt});
    if (bycmd)
      apb(1'b1, OFS_CMD, 32'h10);
    else
    begin
      ign_set(1'b0);
      wait_sig(0, 1'b0, n);
      chk(32'(n >= (DB - 1) * TK && n <= (DB + 1) * TK + 8), 32'h1, "deb");
    end
    repeat (2) @(negedge pclk);
    chk(osc, 1'b0, "osc sleep");
    chk(pso, !opt[6], "pwr sleep");
    // Wake pulse must outlast the input synchroniser
    ign_set(1'b0);
    repeat (4) @(posedge pclk);
    ign_set(1'b1);
    wait_sig(1, 1'b1, n);
    chk(32'(n >= w - TK && n <= w + 2 * TK + 8), 32'h1, "wake");
    repeat (2) @(negedge pclk);
    chk(pso, opt[6], "pwr run");
    chk(osc, 1'b1, "osc run");
  endtask

  initial
  begin
    {psel, penable, pwrite, attn, busy, txl, preq} = 7'h00;
    {m_s, b_s, l_s} = 3'h6;
    {vpw, kl_n, pw_n} = 3'h3;
    ign_on = 1'b1;
    act = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    presetn = 1'b0;
    err_total = 0;
    tests_run = 0;
    cyc = 0;
    rows = '{'{5'h01, 4'h8, 3'h6, 1'h0, 1'h1, 3'h5, 3'h0},
             '{5'h02, 4'h4, 3'h7, 1'h1, 1'h0, 3'h1, 3'h1},
             '{5'h04, 4'h2, 3'h4, 1'h0, 1'h1, 3'h3, 3'h2},
             '{5'h08, 4'h1, 3'h0, 1'h1, 1'h0, 3'h1, 3'h6},
             '{5'h05, 4'hf, 3'h3, 1'h1, 1'h1, 3'h7, 3'h5},
             '{5'h0a, 4'h0, 3'h6, 1'h0, 1'h1, 3'h1, 3'h0}};
    do_reset(3'h6);
    chk(srl, 1'b1, "rx idle");
    chk(pso, 1'b0, "pwr default");
    apb(1'b0, OFS_POWER_OPT, 32'h0);
    chk(rd, 32'h80, "opt reset");
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd[7:3], 5'h04, "status");
    apb(1'b0, 8'h10, 32'h0);
    chk(er, 1'b1, "unmapped err");
    chk(rd, 32'h0000_0000, "unmapped data");
    apb(1'b1, OFS_BAUD_PARAM, 32'h0000_0100);
    apb(1'b0, OFS_BAUD_PARAM, 32'h0000_0000);
    chk(rd, 32'h0000_0100, "baud param");
    chk(baudc, 16'h0100, "baud programmed");
    for (int i = 0; i < 6; i++)
    begin
      apb(1'b1, OFS_CMD, {27'h0, rows[i].cmd});
      @(posedge pclk);
      act <= rows[i].act;
      {pw_n, kl_n, vpw} <= rows[i].pins;
      preq <= rows[i].req;
      txl <= rows[i].tx;
      repeat (5) @(posedge pclk);
      @(negedge pclk);
      chk(cfg, rows[i].cfg, "cmd cfg");
      chk({srx_n, stx_n, vrx_n, vtx_n}, 4'(~rows[i].act), "leds");
      chk(dom, rows[i].dom, "bus level");
      chk(negd, rows[i].req, "neg line");
      chk(stx, rows[i].tx, "tx line");
    end
    @(posedge pclk);
    {m_s, b_s, l_s} <= 3'h1;
    repeat (8) @(negedge pclk);
    chk(cfg, 3'h1, "strap ignored");
    do_reset(3'h1);
    apb(1'b1, OFS_POWER_OPT, 32'h0);
    @(posedge pclk);
    busy <= 1'b1;
    attn <= 1'b1;
    @(posedge pclk);
    attn <= 1'b0;
    repeat (4) @(negedge pclk);
    chk(pso, 1'b1, "busy high");
    chk(rts, 1'b1, "rts");
    chk(ign, 1'b0, "rts held");
    @(posedge pclk);
    busy <= 1'b0;
    repeat (6) @(negedge pclk);
    chk(pso, 1'b0, "busy low");
    chk(ign, 1'b1, "rts released");
    chk(rts, 1'b0, "rts off");
    sleep_wake(8'h84, 1'b0);
    sleep_wake(8'h86, 1'b0);
    sleep_wake(8'hc0, 1'b1);
    report_and_stop();
  end
endmodule
`default_nettype wire
